// file: hdl/epcs_seq.sv
// charging-case sequencer for two earbud pogo lines
// assumes external switches, open-drain pads with pull-up and a lid sensor
// Notes on behaviour
// [RQ1] both ends exchange bytes as asynchronous frames at 1200 baud
// [RQ2] with no exchange running, lines sit at the charging level
// [RQ3] a falling lid-sensor level means lid closed and starts a sequence
// [RQ4] before command bytes, a high-low-high start pattern is sent
// [RQ5] after the pattern the command bytes 0x9a then 0x5a are sent
// [RQ6] the right earbud answers the command with byte 0x6a
// [RQ7] charging closes charge switch, opens comm switch; never both closed
// [RQ8] communicating closes comm switch, opens charge switch; idles high
// [RQ9] transmit is open-drain: only a low is driven, high is released
// [RQ10] all sequencing steps on a 10 ms tick from the clock; lid start, end of send and early answers step without a tick
// [RQ11] valid answer flashes led once right, twice left, thrice both
// [RQ12] left and right earbuds answer with distinguishable bytes
// [RQ13] two channels on split lines exchange with both at once
// [RQ14] one channel on two lines talks to one earbud at a time
// [RQ15] joined lines: case alone starts, both earbuds get the broadcast
// [RQ16] released line reads high, pulled line reads low
// [RQ17] frames are one start, eight data lsb first, no parity, one stop
// [RQ18] no answer within a tick budget ends without flash, back to charge
// [RQ19] each start pattern segment lasts a set number of ticks
`include "epcs_cfg.svh"

module epcs_seq #(
  parameter int         TICK_CYCLES = `EPCS_TICK_CYCLES,
  parameter int         BIT_CYCLES  = `EPCS_BIT_CYCLES,
  parameter int         PAT_TICKS   = `EPCS_PAT_TICKS,
  parameter int         RSP_TICKS   = `EPCS_RSP_TICKS,
  parameter int         FLASH_TICKS = `EPCS_FLASH_TICKS,
  parameter int         FIFO_DEPTH  = `EPCS_FIFO_DEPTH,
  parameter logic [7:0] RSP_RIGHT   = `EPCS_RSP_RIGHT,
  parameter logic [7:0] RSP_LEFT    = `EPCS_RSP_LEFT
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  input  wire epcs_pkg::epcs_topo_t i_topology,
  input  wire logic                 i_lid_sense,
  input  wire logic [1:0]           i_line,
  output logic [1:0]                o_line_out,
  output logic [1:0]                o_line_oe_n,
  output logic [1:0]                o_charge_sw,
  output logic [1:0]                o_comm_sw,
  output logic                      o_led,
  output logic                      o_busy
);
  import epcs_pkg::*;

  localparam int SW = `EPCS_SEG_W;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int BW = $clog2(BIT_CYCLES);
  localparam logic [TW-1:0] TICK_LAST  = TW'(TICK_CYCLES - 1);
  localparam logic [BW-1:0] BIT_LAST   = BW'(BIT_CYCLES - 1);
  localparam logic [SW-1:0] PAT_LAST   = SW'(PAT_TICKS - 1);
  localparam logic [SW-1:0] RSP_LAST   = SW'(RSP_TICKS - 1);
  localparam logic [SW-1:0] FLASH_LAST = SW'(FLASH_TICKS - 1);
  localparam logic [3:0]    STOP_BIT   = 4'(`EPCS_FRAME_BITS - 1);

  generate
    if (TICK_CYCLES < 2 || BIT_CYCLES < 4 || PAT_TICKS < 1 ||
        RSP_TICKS < 1 || FLASH_TICKS < 1 || PAT_TICKS >= (1 << SW) ||
        RSP_TICKS >= (1 << SW) || FLASH_TICKS >= (1 << SW)) begin : g_bad
      $error("epcs_seq: parameter out of range");
    end
  endgenerate

  epcs_state_t   state_reg;
  epcs_state_t   state_next;
  logic [TW-1:0] tick_cnt_reg;
  logic [SW-1:0] seg_reg;
  logic [SW-1:0] seg_next;
  logic          lid_prev_reg;
  logic          pass_reg;
  logic          pass_next;
  logic [1:0]    got_reg;
  logic [1:0]    got_next;
  logic [1:0]    cmd_idx_reg;
  logic [1:0]    cmd_idx_next;
  logic          send_go_reg;
  logic          send_go_next;
  logic [1:0]    flash_left_reg;
  logic [1:0]    flash_left_next;
  logic          led_reg;
  logic          led_next;
  logic [1:0]    chg_reg;
  logic [1:0]    comm_reg;
  logic [1:0]    oe_n_reg;
  logic          tx_busy_reg;
  logic [9:0]    tx_sh_reg;
  logic [3:0]    tx_bit_reg;
  logic [BW-1:0] tx_cnt_reg;
  logic [7:0]    rx_data [2];
  logic [1:0]    rx_valid;
  logic [1:0]    rx_en;
  logic [1:0]    hit_right;
  logic [1:0]    hit_left;

  wire           tick;
  wire           lid_fall;
  wire           shared;
  wire [1:0]     act;
  wire           in_comm;
  wire           pat_lo;
  wire           pat_done;
  wire           rsp_end;
  wire [1:0]     got_hit;
  wire           all_in;
  wire           cmd_push;
  wire           cmd_fire;
  wire [7:0]     cmd_byte;
  wire           fifo_in_ready;
  wire           fifo_out_valid;
  wire [7:0]     fifo_out_data;
  wire           tx_pop;
  wire           tx_bit_end;
  wire           tx_low;
  wire           send_done;

  // [RQ10] free-running tick
  assign tick     = tick_cnt_reg == TICK_LAST;
  // [RQ3] lid closing edge
  assign lid_fall = lid_prev_reg && !i_lid_sense;

  // [RQ14] one line per pass
  assign shared = i_topology == EPCS_TOPO_SHARED;
  // [RQ13] split and joined lines both active
  assign act    = shared ? (pass_reg ? 2'b10 : 2'b01) : 2'b11;

  assign pat_lo   = state_reg == EPCS_ST_PAT_LO;
  assign in_comm  = pat_lo || state_reg == EPCS_ST_SEND ||
                    state_reg == EPCS_ST_WAIT;
  // [RQ19] segment length in ticks
  assign pat_done = tick && seg_reg == PAT_LAST;
  // [RQ18] answer budget
  assign rsp_end  = tick && seg_reg == RSP_LAST;

  // [RQ12] answer byte tells which earbud
  assign got_hit = got_reg | {|hit_left, |hit_right};
  assign all_in  = (got_hit & act) == act;

  // [RQ5] two command bytes, high byte first
  assign cmd_push = state_reg == EPCS_ST_SEND && cmd_idx_reg != 2'h2;
  assign cmd_fire = cmd_push && fifo_in_ready;
  assign cmd_byte = (cmd_idx_reg == 2'h0) ? `EPCS_CMD_HI : `EPCS_CMD_LO;

  assign tx_pop     = fifo_out_valid && !tx_busy_reg && send_go_reg &&
                      state_reg == EPCS_ST_SEND;
  // [RQ1] bit period from baud rate
  assign tx_bit_end = tx_busy_reg && tx_cnt_reg == BIT_LAST;
  assign tx_low     = tx_busy_reg && !tx_sh_reg[0];
  assign send_done  = send_go_reg && cmd_idx_reg == 2'h2 &&
                      !fifo_out_valid && !tx_busy_reg;

  // [RQ9] pad output fixed low, enable carries data
  assign o_line_out  = 2'b00;
  assign o_line_oe_n = oe_n_reg;
  assign o_charge_sw = chg_reg;
  assign o_comm_sw   = comm_reg;
  assign o_led       = led_reg;
  assign o_busy      = state_reg != EPCS_ST_IDLE;

  epcs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (cmd_push),
    .i_in_data   (cmd_byte),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (tx_pop)
  );

  generate
    for (genvar g = 0; g < 2; g++) begin : g_line
      assign rx_en[g] = state_reg == EPCS_ST_WAIT && act[g];
      epcs_uart_rx #(
        .BIT_CYCLES (BIT_CYCLES)
      ) u_rx (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_en     (rx_en[g]),
        .i_line   (i_line[g]),
        .o_valid  (rx_valid[g]),
        .o_data   (rx_data[g])
      );
      // [RQ6] right answer byte
      assign hit_right[g] = rx_valid[g] && rx_data[g] == RSP_RIGHT;
      assign hit_left[g]  = rx_valid[g] && rx_data[g] == RSP_LEFT;
    end
  endgenerate

  always_comb begin
    state_next      = state_reg;
    seg_next        = tick ? seg_reg + 1'b1 : seg_reg;
    pass_next       = pass_reg;
    got_next        = got_reg;
    cmd_idx_next    = cmd_fire ? cmd_idx_reg + 2'h1 : cmd_idx_reg;
    send_go_next    = send_go_reg;
    flash_left_next = flash_left_reg;
    led_next        = led_reg;
    case (state_reg)
      EPCS_ST_IDLE: begin
        led_next = 1'b0;
        // [RQ3] lid close starts sequence
        if (lid_fall) begin
          state_next   = EPCS_ST_PAT_HI1;
          seg_next     = '0;
          pass_next    = 1'b0;
          got_next     = 2'b00;
          cmd_idx_next = 2'h0;
        end
      end
      // [RQ4] high, low, high pattern
      EPCS_ST_PAT_HI1: begin
        if (pat_done) begin
          state_next = EPCS_ST_PAT_LO;
          seg_next   = '0;
        end
      end
      EPCS_ST_PAT_LO: begin
        if (pat_done) begin
          state_next = EPCS_ST_PAT_HI2;
          seg_next   = '0;
        end
      end
      EPCS_ST_PAT_HI2: begin
        if (pat_done) begin
          state_next   = EPCS_ST_SEND;
          seg_next     = '0;
          send_go_next = 1'b0;
          cmd_idx_next = 2'h0;
        end
      end
      // one idle tick at logic high before the first frame
      EPCS_ST_SEND: begin
        if (tick) begin
          send_go_next = 1'b1;
        end
        if (send_done) begin
          state_next   = EPCS_ST_WAIT;
          seg_next     = '0;
          send_go_next = 1'b0;
        end
      end
      EPCS_ST_WAIT: begin
        got_next = got_hit;
        if (all_in || rsp_end) begin
          seg_next = '0;
          if (shared && !pass_reg) begin
            // [RQ14] second pass for the left line
            state_next   = EPCS_ST_PAT_HI1;
            pass_next    = 1'b1;
            cmd_idx_next = 2'h0;
          end else if (got_hit != 2'b00) begin
            // [RQ11] flash count equals answer bits
            state_next      = EPCS_ST_FLASH;
            flash_left_next = got_hit;
            led_next        = 1'b1;
          end else begin
            // [RQ18] silent earbuds, back to charging
            state_next = EPCS_ST_IDLE;
          end
        end
      end
      EPCS_ST_FLASH: begin
        if (tick && seg_reg == FLASH_LAST) begin
          seg_next = '0;
          if (led_reg) begin
            led_next        = 1'b0;
            flash_left_next = flash_left_reg - 2'h1;
          end else if (flash_left_reg == 2'h0) begin
            state_next = EPCS_ST_IDLE;
          end else begin
            led_next = 1'b1;
          end
        end
      end
      default: begin
        state_next = EPCS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg      <= EPCS_ST_IDLE;
      tick_cnt_reg   <= '0;
      seg_reg        <= '0;
      lid_prev_reg   <= 1'b1;
      pass_reg       <= 1'b0;
      got_reg        <= 2'b00;
      cmd_idx_reg    <= 2'h0;
      send_go_reg    <= 1'b0;
      flash_left_reg <= 2'h0;
      led_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      tick_cnt_reg   <= tick ? '0 : tick_cnt_reg + 1'b1;
      seg_reg        <= seg_next;
      lid_prev_reg   <= i_lid_sense;
      pass_reg       <= pass_next;
      got_reg        <= got_next;
      cmd_idx_reg    <= cmd_idx_next;
      send_go_reg    <= send_go_next;
      flash_left_reg <= flash_left_next;
      led_reg        <= led_next;
    end
  end

  // [RQ2] charging by default and between exchanges
  // [RQ7] switch pair driven from one term, never both closed
  // [RQ8] comm path during pattern low, send and wait
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chg_reg  <= 2'b11;
      comm_reg <= 2'b00;
      oe_n_reg <= 2'b11;
    end else begin
      chg_reg  <= ~(act & {2{in_comm}});
      comm_reg <= act & {2{in_comm}};
      oe_n_reg <= ~(act & {2{in_comm && (pat_lo || tx_low)}});
    end
  end

  // [RQ17] 8N1 transmit shifter
  // [RQ15] one shifter feeds every active line
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg   <= 10'h3ff;
      tx_bit_reg  <= 4'h0;
      tx_cnt_reg  <= '0;
    end else if (tx_pop) begin
      tx_busy_reg <= 1'b1;
      tx_sh_reg   <= {1'b1, fifo_out_data, 1'b0};
      tx_bit_reg  <= 4'h0;
      tx_cnt_reg  <= '0;
    end else if (tx_bit_end) begin
      tx_cnt_reg  <= '0;
      tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
      tx_bit_reg  <= tx_bit_reg + 4'h1;
      tx_busy_reg <= tx_bit_reg != STOP_BIT;
    end else if (tx_busy_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
    end
  end

  a_switch_excl: // [RQ7]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_charge_sw & o_comm_sw) == 2'b00)
    else $error("charge and comm switches closed together");

  a_idle_charge: // [RQ2]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_IDLE && $past(state_reg) == EPCS_ST_IDLE)
      |-> (o_charge_sw == 2'b11 && o_line_oe_n == 2'b11))
    else $error("line not charging while idle");

  a_lid_start: // [RQ3]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_IDLE && $fell(i_lid_sense))
      |=> state_reg == EPCS_ST_PAT_HI1)
    else $error("lid close did not start the pattern");

  a_pat_order: // [RQ4]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_PAT_LO ##1 state_reg != EPCS_ST_PAT_LO)
      |-> state_reg == EPCS_ST_PAT_HI2 && $past(tick))
    else $error("pattern low not followed by high");

  a_pat_low_drive: // [RQ4]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (pat_lo && $past(pat_lo)) |-> (o_line_oe_n == ~act &&
      (o_charge_sw & act) == 2'b00))
    else $error("pattern low segment not pulling the line");

  a_cmd_order: // [RQ5]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tx_pop |-> fifo_out_data == ($past(tx_busy_reg) ? `EPCS_CMD_LO :
      `EPCS_CMD_HI))
    else $error("command byte out of order");

  a_comm_path: // [RQ8]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_WAIT && $past(state_reg) == EPCS_ST_WAIT)
      |-> (o_comm_sw == act && o_charge_sw == ~act &&
      o_line_oe_n == 2'b11))
    else $error("comm path not set while waiting for answer");

  a_open_drain: // [RQ9]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_line_out == 2'b00) && ((~o_line_oe_n & ~o_comm_sw) == 2'b00))
    else $error("line driven outside the comm path or driven high");

  a_tick_pace: // [RQ10]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_PAT_HI1 && !tick) |=>
      (state_reg == EPCS_ST_PAT_HI1 && seg_reg == $past(seg_reg)))
    else $error("pattern stepped without a tick");

  a_flash_count: // [RQ11]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_WAIT ##1 state_reg == EPCS_ST_FLASH)
      |-> (flash_left_reg == got_reg && got_reg != 2'b00) ##1 o_led)
    else $error("flash count does not match answers");

  a_timeout_idle: // [RQ18]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state_reg == EPCS_ST_WAIT && rsp_end && got_hit == 2'b00 &&
      !(shared && !pass_reg)) |=> state_reg == EPCS_ST_IDLE ##1 !o_led)
    else $error("timeout did not end the exchange");

  a_shared_single: // [RQ14]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (shared && $past(shared)) |-> $countones(o_comm_sw) <= 1)
    else $error("shared channel talking to both lines");

  a_split_both: // [RQ13]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!shared && state_reg == EPCS_ST_SEND &&
      $past(state_reg) == EPCS_ST_SEND) |-> o_comm_sw == 2'b11)
    else $error("both lines not served together");

  a_tx_start: // [RQ17]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tx_pop |=> tx_low ##1 (o_line_oe_n & act) == 2'b00)
    else $error("frame does not open with a low start bit");

endmodule

// file: hdl/epcs_cfg.svh
// constants of the pogo-line sequencer: clock, timing, command bytes
// assumes a 125 MHz system clock; included by bare name
`ifndef EPCS_CFG_SVH
`define EPCS_CFG_SVH

`define EPCS_CLK_HZ      125000000
`define EPCS_TICK_MS     10
`define EPCS_TICK_CYCLES (`EPCS_CLK_HZ / 1000 * `EPCS_TICK_MS)
`define EPCS_BAUD        1200
`define EPCS_BIT_CYCLES  (`EPCS_CLK_HZ / `EPCS_BAUD)
`define EPCS_FRAME_BITS  10
`define EPCS_CMD_HI      8'h9a
`define EPCS_CMD_LO      8'h5a
`define EPCS_RSP_RIGHT   8'h6a
`define EPCS_RSP_LEFT    8'h6b
`define EPCS_PAT_TICKS   4
`define EPCS_RSP_TICKS   50
`define EPCS_FLASH_TICKS 20
`define EPCS_FIFO_DEPTH  32
`define EPCS_SEG_W       16

`endif

// file: hdl/epcs_pkg.sv
// types of the pogo-line sequencer
// assumes nothing beyond a SystemVerilog compiler
package epcs_pkg;

  typedef enum logic [2:0] {
    EPCS_ST_IDLE    = 3'h0,
    EPCS_ST_PAT_HI1 = 3'h1,
    EPCS_ST_PAT_LO  = 3'h2,
    EPCS_ST_PAT_HI2 = 3'h3,
    EPCS_ST_SEND    = 3'h4,
    EPCS_ST_WAIT    = 3'h5,
    EPCS_ST_FLASH   = 3'h6
  } epcs_state_t;

  typedef enum logic [1:0] {
    EPCS_TOPO_SPLIT  = 2'h0,
    EPCS_TOPO_SHARED = 2'h1,
    EPCS_TOPO_JOINED = 2'h2
  } epcs_topo_t;

endpackage

// file: hdl/epcs_fifo.sv
// flip-flop FIFO with valid/ready on both sides
// assumes one clock; depth is a power of two
`include "epcs_cfg.svh"

module epcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `EPCS_FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("epcs_fifo: depth must be a power of two above one");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              push;
  wire              pop;
  wire              full;
  wire  [AW:0]      level;

  assign full        = (wr_reg[AW] != rd_reg[AW]) &&
                       (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign level       = wr_reg - rd_reg;
  assign o_in_ready  = !full;
  assign o_out_valid = wr_reg != rd_reg;
  assign o_out_data  = mem_reg[rd_reg[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

  a_fifo_level_step: // [RQ5]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (push && !pop) |=> (level == $past(level) + 1'b1))
    else $error("fifo level did not rise on push");

endmodule

// file: hdl/epcs_uart_rx.sv
// serial byte receiver for one pogo line, 8N1, least significant bit first
// assumes the line input is synchronous to i_clk; idle level is high
`include "epcs_cfg.svh"

module epcs_uart_rx #(
  parameter int BIT_CYCLES = `EPCS_BIT_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_en,
  input  wire logic       i_line,
  output logic            o_valid,
  output logic [7:0]      o_data
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);

  generate
    if (BIT_CYCLES < 4) begin : g_bad
      $error("epcs_uart_rx: bit period too short");
    end
  endgenerate

  logic          prev_reg;
  logic          busy_reg;
  logic [CW-1:0] cnt_reg;
  logic [3:0]    bit_reg;
  logic [7:0]    sh_reg;
  logic          valid_reg;
  logic [7:0]    data_reg;
  wire           start;
  wire           sample;

  // released line reads high, pulled line reads low
  // [RQ16] falling edge start
  assign start  = i_en && !busy_reg && prev_reg && !i_line;
  assign sample = busy_reg &&
                  (cnt_reg == ((bit_reg == 4'h0) ? HALF : FULL));
  assign o_valid = valid_reg;
  assign o_data  = data_reg;

  // [RQ17] start, data, stop
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_reg  <= 1'b1;
      busy_reg  <= 1'b0;
      cnt_reg   <= '0;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      valid_reg <= 1'b0;
      data_reg  <= 8'h00;
    end else begin
      prev_reg  <= i_line;
      valid_reg <= 1'b0;
      if (!i_en) begin
        busy_reg <= 1'b0;
      end else if (start) begin
        busy_reg <= 1'b1;
        cnt_reg  <= '0;
        bit_reg  <= 4'h0;
      end else if (sample) begin
        cnt_reg <= '0;
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h0 && i_line) begin
          busy_reg <= 1'b0;
        end else if (bit_reg == 4'h9) begin
          busy_reg <= 1'b0;
          if (i_line) begin
            valid_reg <= 1'b1;
            data_reg  <= sh_reg;
          end
        end else if (bit_reg != 4'h0) begin
          sh_reg <= {i_line, sh_reg[7:1]};
        end
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  a_rx_stop_high: // [RQ17]
  assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_valid |-> ($past(i_line) && $past(busy_reg) && !busy_reg))
    else $error("byte accepted without a high stop bit");

endmodule

// file: tb/epcs_bud.sv
// earbud model on one pogo line: takes 8n1 bytes, answers a command
// assumes i_line is the resolved wire; o_pull high pulls the wire low
module epcs_bud #(
  parameter int         BIT = 8,
  parameter logic [7:0] RSP = 8'h6a
) (
  input  wire logic i_clk,
  input  wire logic i_en,
  input  wire logic i_line,
  output logic      o_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  b;
  logic [15:0] h;
  logic [9:0]  f;
  initial begin
    o_pull = 1'b0;
    h = 16'h0000;
    f = {1'b1, RSP, 1'b0};
    forever begin
      @(posedge i_clk);
      if (!i_line) begin
        repeat (BIT / 2) @(posedge i_clk);
        for (int k = 0; k < 8; k++) begin
          repeat (BIT) @(posedge i_clk);
          b[k] = i_line;
        end
        repeat (BIT) @(posedge i_clk);
        if (i_line) h = {h[7:0], b};
        while (!i_line) @(posedge i_clk);
        // own answer byte after the command word
        if (i_en && h == 16'h9a5a) begin
          h = 16'h0000;
          repeat (2 * BIT) @(posedge i_clk);
          for (int k = 0; k < 10; k++) begin
            o_pull <= !f[k];
            repeat (BIT) @(posedge i_clk);
          end
        end
      end
    end
  end
endmodule

// file: tb/tb_epcs_seq.sv
// self-checking bench of the pogo-line sequencer with two earbud models
// assumes shortened tick, bit and segment counts
`include "epcs_cfg.svh"
module tb_epcs_seq;
  timeunit 1ns;
  timeprecision 1ns;
  import epcs_pkg::*;
  localparam int BITC = 8;
  logic       clk, arst_n, lid, led, busy, pled, pbusy;
  epcs_topo_t topo;
  logic [1:0] line, oe_n, lout, chg, comm, pull, en;
  int         error_cnt, n_tests, cyc, fl;
  int         q[$];
  logic [31:0] rs;
  wire logic       wj = &oe_n & ~|pull;
  wire logic [1:0] nchg = ~chg;
  assign line = (topo == EPCS_TOPO_JOINED) ? {2{wj}} : oe_n & ~pull;
  epcs_seq #(.TICK_CYCLES(50), .BIT_CYCLES(BITC), .PAT_TICKS(2),
    .RSP_TICKS(8), .FLASH_TICKS(2)) u_epcs_seq (.i_clk(clk),
    .i_arst_n(arst_n), .i_topology(topo), .i_lid_sense(lid),
    .i_line(line), .o_line_out(lout), .o_line_oe_n(oe_n),
    .o_charge_sw(chg), .o_comm_sw(comm), .o_led(led), .o_busy(busy));
  epcs_bud #(.BIT(BITC), .RSP(`EPCS_RSP_RIGHT)) u_epcs_bud (.i_clk(clk),
    .i_en(en[0]), .i_line(line[0]), .o_pull(pull[0]));
  epcs_bud #(.BIT(BITC), .RSP(`EPCS_RSP_LEFT)) u_epcs_bud_1 (.i_clk(clk),
    .i_en(en[1]), .i_line(line[1]), .o_pull(pull[1]));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic run(input epcs_topo_t t, input logic [1:0] e);
    int n;
    @(posedge clk);
    topo <= t;
    en <= e;
    q.push_back(e[0] + 2 * e[1]);
    repeat (2) @(posedge clk);
    lid <= 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(busy, 1'b1);
    @(posedge clk);
    lid <= 1'b1;
    @(posedge clk);
    lid <= 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    repeat (5) @(negedge clk);
    chk(busy, 1'b0);
    chk(chg, 2'h3);
    chk(line, 2'h3);
    chk(led, 1'b0);
    @(posedge clk);
    lid <= 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(negedge clk) begin
    if (arst_n) begin
      chk(comm, nchg);
      chk(lout, 2'h0);
      if (busy && led && !pled) fl++;
      if (pbusy && !busy) begin
        chk(fl, q.pop_front());
        fl = 0;
      end
    end
    pled = led;
    pbusy = busy;
  end
  initial begin
    arst_n = 1'b0;
    lid = 1'b1;
    topo = EPCS_TOPO_SPLIT;
    en = 2'h0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    fl = 0;
    rs = 32'd10002;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk({chg, comm, oe_n, led, busy}, 8'hcc);
    run(EPCS_TOPO_SPLIT, 2'h3);
    run(EPCS_TOPO_SPLIT, 2'h1);
    run(EPCS_TOPO_SPLIT, 2'h2);
    run(EPCS_TOPO_SPLIT, 2'h0);
    run(EPCS_TOPO_SHARED, 2'h3);
    run(EPCS_TOPO_JOINED, 2'h2);
    run(EPCS_TOPO_JOINED, 2'h1);
    run(epcs_topo_t'(2'h3), 2'h1);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      run(rs[0] ? EPCS_TOPO_SHARED : EPCS_TOPO_SPLIT, rs[3:2]);
    end
    tally_and_finish();
  end
endmodule
